// file: bench/lbus_master_test.sv
/*
 * Scenario testbench for lbus_master with a slave model on its bus side.
 * Assumes lbus_pkg, cmd_fifo and lbus_master are compiled first.
 */
`default_nettype none
module lbus_master_test
    import lbus_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] RD_KEY = 32'hA5A5_0F0F;
    localparam int          DTO    = 20;
    logic        clk, sys_rst, cmd_valid, cmd_ready, rsp_valid, cmd_rejected, pav_ff;
    logic        primary_addr_valid, bus_rnw, target_addr_ack, target_wait;
    logic        target_write_complete, target_read_complete, no_ack, hold_wait, no_comp;
    logic [3:0]  transfer_size_code, byte_lane_enables, ack_dly, comp_dly;
    logic [2:0]  transfer_type;
    logic [31:0] bus_addr, bus_wr_data, target_rd_data;
    cmd_t        cmd_in;
    rsp_t        rsp_out;
    cmd_t        phase_q[$];
    int          err_count, num_checks, last_cyc;

    lbus_master #(.DATA_TIMEOUT(DTO)) u_dut (.clk, .sys_rst, .cmd_in, .cmd_valid, .cmd_ready,
        .rsp_out, .rsp_valid, .cmd_rejected, .primary_addr_valid, .bus_rnw, .bus_addr,
        .transfer_size_code, .byte_lane_enables, .transfer_type, .bus_wr_data,
        .target_addr_ack, .target_wait, .target_write_complete, .target_read_complete,
        .target_rd_data);
    lbus_slave_model #(.RD_KEY(RD_KEY)) u_slave (.clk, .sys_rst, .primary_addr_valid,
        .bus_rnw, .bus_addr, .ack_dly, .comp_dly, .no_ack, .hold_wait, .no_comp,
        .target_addr_ack, .target_wait, .target_write_complete, .target_read_complete,
        .target_rd_data);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #2;
    endtask
    always @(posedge clk) begin
        pav_ff <= primary_addr_valid;
        if (primary_addr_valid === 1'b1 && pav_ff !== 1'b1) begin
            phase_q.push_back({bus_rnw, transfer_size_code, byte_lane_enables, bus_addr,
                bus_wr_data});
            chk(transfer_type === TYPE_MEMORY, "transfer type");
        end
    end
    task automatic send(input cmd_t c);
        logic ok;
        cmd_in = c;
        cmd_valid = 1'b1;
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            ok = (cmd_ready === 1'b1);
            tick();
        end
        cmd_valid = 1'b0;
        chk(ok, "command not taken");
        if (!ok) end_sim();
    endtask
    task automatic wait_rsp(input cmd_t c, input logic exp_to);
        cmd_t ph;
        logic got;
        got = 1'b0;
        for (last_cyc = 0; last_cyc < 80 && !got; last_cyc++) begin
            tick();
            got = (rsp_valid === 1'b1);
        end
        chk(got, "no response");
        if (!got) begin
            end_sim();
        end else begin
            ph = (phase_q.size() > 0) ? phase_q.pop_front() : '0;
            chk(ph === c, "address phase fields");
            chk(rsp_out.timeout === exp_to, "timeout flag");
            chk(rsp_out.rnw === c.rnw, "response direction");
            if (c.rnw && !exp_to) chk(rsp_out.rdata === (c.addr ^ RD_KEY), "read data");
        end
    endtask
    task automatic wait_rej();
        logic got;
        got = 1'b0;
        for (int i = 0; i < 20 && !got; i++) begin
            tick();
            got = (cmd_rejected === 1'b1);
        end
        chk(got, "illegal command not refused");
        if (!got) end_sim();
    endtask
    task automatic t_single();
        cmd_t w, r;
        w = '{1'b0, SIZE_SINGLE, 4'h3, 32'h0000_1004, 32'hCAFE_0001};
        r = '{1'b1, SIZE_SINGLE, 4'hC, 32'h0000_1008, 32'h0};
        send(w);
        tick();
        send(r);
        wait_rsp(w, 1'b0);
        wait_rsp(r, 1'b0);
    endtask
    task automatic t_sizes();
        cmd_t c;
        for (int i = 0; i < 20; i++) begin
            c = '{1'b1, (i < 16) ? 4'(i) : 4'(i - 6), (i < 16) ? 4'h4 : 4'h0,
                32'(i) * 32'h40, 32'h0};
            send(c);
            if (i < 4 || (i >= 10 && i <= 13)) wait_rsp(c, 1'b0);
            else wait_rej();
            tick();
        end
    endtask
    task automatic t_timeouts();
        cmd_t c;
        logic quiet;
        c = '{1'b1, SIZE_SINGLE, 4'hF, 32'h0000_3000, 32'h0};
        no_ack = 1'b1;
        hold_wait = 1'b1;
        send(c);
        quiet = 1'b1;
        repeat (40) begin
            tick();
            if (rsp_valid !== 1'b0) quiet = 1'b0;
        end
        chk(quiet, "timeout while wait held");
        hold_wait = 1'b0;
        wait_rsp(c, 1'b1);
        chk(last_cyc >= ADDR_TIMEOUT_CLK, "address timeout too early");
        no_ack = 1'b0;
        no_comp = 1'b1;
        send(c);
        wait_rsp(c, 1'b1);
        chk(last_cyc >= DTO, "data timeout too early");
        no_comp = 1'b0;
    endtask
    task automatic t_fifo();
        logic ok;
        int n;
        n = 0;
        ok = 1'b1;
        comp_dly = 4'hA;
        ack_dly = 4'h3;
        cmd_valid = 1'b1;
        while (ok && n < 16) begin
            cmd_in = '{1'b1, SIZE_SINGLE, 4'hF, 32'h0000_4000 + 32'(n) * 32'h4, 32'h0};
            ok = (cmd_ready === 1'b1);
            tick();
            if (ok) n++;
        end
        cmd_valid = 1'b0;
        chk(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 2, "queue depth");
        for (int k = 0; k < n; k++) begin
            wait_rsp('{1'b1, SIZE_SINGLE, 4'hF, 32'h0000_4000 + 32'(k) * 32'h4, 32'h0}, 1'b0);
        end
        comp_dly = 4'h3;
        ack_dly = 4'h0;
    endtask
    initial begin
        err_count = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_in = '0;
        no_ack = 1'b0;
        hold_wait = 1'b0;
        no_comp = 1'b0;
        ack_dly = 4'h0;
        comp_dly = 4'h3;
        repeat (12) @(posedge clk);
        #2;
        sys_rst = 1'b0;
        chk(cmd_ready === 1'b1 && primary_addr_valid === 1'b0, "reset state");
        t_single();
        t_sizes();
        t_timeouts();
        t_fifo();
        end_sim();
    end
endmodule
`default_nettype wire

// file: bench/lbus_slave_model.sv
/*
 * Slave model for the local bus: acknowledges and completes one transfer at a time.
 * Assumes it shares clk and sys_rst with the controller under test.
 */
`default_nettype none
module lbus_slave_model
    import lbus_pkg::*;
#(
    parameter logic [31:0] RD_KEY = 32'hA5A5_0F0F
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        primary_addr_valid,
    input  wire logic        bus_rnw,
    input  wire logic [31:0] bus_addr,
    input  wire logic [3:0]  ack_dly,
    input  wire logic [3:0]  comp_dly,
    input  wire logic        no_ack,
    input  wire logic        hold_wait,
    input  wire logic        no_comp,
    output logic             target_addr_ack,
    output logic             target_wait,
    output logic             target_write_complete,
    output logic             target_read_complete,
    output logic [31:0]      target_rd_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] st_ff;
    logic [3:0] cnt_ff;
    logic       pav_ff;
    always_ff @(posedge clk) begin
        pav_ff <= primary_addr_valid;
        target_addr_ack <= 1'b0;
        target_write_complete <= 1'b0;
        target_read_complete <= 1'b0;
        target_wait <= hold_wait && primary_addr_valid;
        target_rd_data <= ~target_rd_data;
        if (sys_rst) begin
            st_ff <= 2'h0;
            cnt_ff <= 4'h0;
            target_rd_data <= 32'h0;
        end else begin
            case (st_ff)
                2'h0: if (primary_addr_valid && !pav_ff && !no_ack) begin
                    st_ff <= 2'h1;
                    cnt_ff <= ack_dly;
                end
                2'h1: if (cnt_ff == 4'h0) begin
                    target_addr_ack <= 1'b1;
                    st_ff <= 2'h2;
                    cnt_ff <= comp_dly;
                end else cnt_ff <= cnt_ff - 4'h1;
                2'h2: if (no_comp) st_ff <= 2'h0;
                else if (cnt_ff == 4'h0) begin
                    st_ff <= 2'h0;
                    target_read_complete <= bus_rnw;
                    target_write_complete <= !bus_rnw;
                    if (bus_rnw) target_rd_data <= bus_addr ^ RD_KEY;
                end else cnt_ff <= cnt_ff - 4'h1;
                default: st_ff <= 2'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: rtl/cmd_fifo.sv
/*
 * Parameterised valid/ready FIFO for queued bus commands.
 * Assumes one clock; push and pop may happen in the same cycle.
 */
`default_nettype none
module cmd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    logic [PW:0]      nxt_count;
    logic             in_ready_ff;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign nxt_count = count_ff + (PW+1)'(push) - (PW+1)'(pop);
    assign in_ready  = in_ready_ff;
    assign out_valid = (count_ff != '0);
    assign out_data  = mem[rd_ptr_ff];

    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr_ff] <= in_data;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
            in_ready_ff <= 1'b1;
        end else begin
            if (push) wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            if (pop)  rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            count_ff <= nxt_count;
            in_ready_ff <= (nxt_count != (PW+1)'(DEPTH));
        end
    end
endmodule
`default_nettype wire

// file: rtl/lbus_master.sv
/*
 * Bus master controller: drives one transaction at a time onto the local
 * bus and returns completion to user logic. Commands queue in a FIFO.
 * Assumes the far end is synchronous logic on the same clock and
 * pipelined slave inputs arrive already registered when not point to point.
 */
// Function
// - 32-bit address, separate read and write buses
// - Address phase: valid until target acknowledge
// - Data phase: acknowledge until read/write complete
// - Read and write phases may overlap; this controller runs one transaction at a time
// - Singles, cachelines, bursts two to sixteen; this controller accepts burst lengths of 1 to 15 lanes
// - Cachelines move exactly 4, 8, 16 words
// - Size 0000 single beat, lanes select bytes
// - Sizes 0001-0011 are cacheline 4/8/16
// - Sizes 1010-1101 are word to octal bursts
// - Reserved size codes never issued
// - Burst length in lanes, never zero
// - Address phase times out after 16 clocks
// - Transactions never aborted once issued; this controller times out the data phase after DATA_TIMEOUT clocks
// - Point to point may drop interface registers
// - Same signal set for every subset
// - No bursts to baseline slaves
// - Transfer type always 000
`default_nettype none
module lbus_master
    import lbus_pkg::*;
#(
    parameter int DATA_TIMEOUT = DATA_TIMEOUT_MAX
) (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire lbus_pkg::cmd_t              cmd_in,
    input  wire logic                        cmd_valid,
    output logic                             cmd_ready,
    output lbus_pkg::rsp_t                   rsp_out,
    output logic                             rsp_valid,
    output logic                             cmd_rejected,
    output logic                             primary_addr_valid,
    output logic                             bus_rnw,
    output logic [lbus_pkg::ADDR_W-1:0]      bus_addr,
    output logic [3:0]                       transfer_size_code,
    output logic [lbus_pkg::BE_W-1:0]        byte_lane_enables,
    output logic [2:0]                       transfer_type,
    output logic [lbus_pkg::DATA_W-1:0]      bus_wr_data,
    input  wire logic                        target_addr_ack,
    input  wire logic                        target_wait,
    input  wire logic                        target_write_complete,
    input  wire logic                        target_read_complete,
    input  wire logic [lbus_pkg::DATA_W-1:0] target_rd_data
);
    import lbus_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} state_t;

    state_t            state_ff;
    state_t            nxt_state;
    cmd_t              cur_ff;
    cmd_t              q_data;
    logic              q_valid;
    logic              q_ready;
    logic [4:0]        atime_ff;
    logic [8:0]        dtime_ff;
    logic              pav_ff;
    logic              rsp_valid_ff;
    rsp_t              rsp_ff;
    logic              rej_ff;
    logic              ack_s1_ff;
    logic              ack_ff;
    logic              wait_s1_ff;
    logic              wait_ff;
    logic              wc_s1_ff;
    logic              wc_ff;
    logic              rc_s1_ff;
    logic              rc_ff;
    logic [DATA_W-1:0] rd_s1_ff;
    logic [DATA_W-1:0] rd_ff;

    cmd_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_data   (cmd_in),
        .in_valid  (cmd_valid),
        .in_ready  (cmd_ready),
        .out_data  (q_data),
        .out_valid (q_valid),
        .out_ready (q_ready)
    );

    // Two-stage capture of slave pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_s1_ff  <= 1'b0;
            ack_ff     <= 1'b0;
            wait_s1_ff <= 1'b0;
            wait_ff    <= 1'b0;
            wc_s1_ff   <= 1'b0;
            wc_ff      <= 1'b0;
            rc_s1_ff   <= 1'b0;
            rc_ff      <= 1'b0;
            rd_s1_ff   <= '0;
            rd_ff      <= '0;
        end else begin
            ack_s1_ff  <= target_addr_ack;
            ack_ff     <= ack_s1_ff;
            wait_s1_ff <= target_wait;
            wait_ff    <= wait_s1_ff;
            wc_s1_ff   <= target_write_complete;
            wc_ff      <= wc_s1_ff;
            rc_s1_ff   <= target_read_complete;
            rc_ff      <= rc_s1_ff;
            rd_s1_ff   <= target_rd_data;
            rd_ff      <= rd_s1_ff;
        end
    end

    // Legal size and length check
    wire is_burst  = (q_data.size >= SIZE_BURST_W) && (q_data.size <= SIZE_BURST_O);
    wire is_line   = (q_data.size >= SIZE_LINE4) && (q_data.size <= SIZE_LINE16);
    wire is_single = (q_data.size == SIZE_SINGLE);
    wire blen_ok   = (q_data.be != '0) && ({1'b0, q_data.be} <= BURST_MAX);
    wire cmd_legal = is_single || is_line || (is_burst && blen_ok);
    wire start     = (state_ff == ST_IDLE) && q_valid && cmd_legal;
    wire reject    = (state_ff == ST_IDLE) && q_valid && !cmd_legal;
    wire addr_to   = (atime_ff == 5'(ADDR_TIMEOUT_CLK - 1)) && !wait_ff;
    wire done_cmp  = cur_ff.rnw ? rc_ff : wc_ff;
    wire data_to   = (dtime_ff == 9'(DATA_TIMEOUT));
    wire fin_data  = (state_ff == ST_DATA) && (done_cmp || data_to);
    wire fin_addr  = (state_ff == ST_ADDR) && !ack_ff && addr_to;

    assign q_ready = start || reject;

    // Sequencer: one outstanding transaction at a time
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: if (start) nxt_state = ST_ADDR;
            ST_ADDR: begin
                if (ack_ff) nxt_state = ST_DATA;
                else if (addr_to) nxt_state = ST_IDLE;
            end
            ST_DATA: if (done_cmp || data_to) nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            cur_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            if (start) cur_ff <= q_data;
        end
    end

    // Address phase valid held until acknowledge or timeout
    always_ff @(posedge clk) begin
        if (sys_rst) pav_ff <= 1'b0;
        else         pav_ff <= (nxt_state == ST_ADDR);
    end

    // Address phase counter, frozen while target waits
    always_ff @(posedge clk) begin
        if (sys_rst || state_ff != ST_ADDR) atime_ff <= '0;
        else if (!wait_ff)                  atime_ff <= atime_ff + 5'h01;
    end

    // Data phase counter
    always_ff @(posedge clk) begin
        if (sys_rst || state_ff != ST_DATA) dtime_ff <= '0;
        else if (!data_to)                  dtime_ff <= dtime_ff + 9'h001;
    end

    // Response to user logic
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_ff       <= '0;
            rej_ff       <= 1'b0;
        end else begin
            rsp_valid_ff <= fin_data || fin_addr;
            rej_ff       <= reject;
            if (fin_data || fin_addr) begin
                rsp_ff.rnw     <= cur_ff.rnw;
                rsp_ff.timeout <= fin_addr || (fin_data && !done_cmp);
                rsp_ff.rdata   <= (fin_data && cur_ff.rnw && done_cmp) ? rd_ff : '0;
            end
        end
    end

    assign primary_addr_valid = pav_ff;
    assign bus_rnw            = cur_ff.rnw;
    assign bus_addr           = cur_ff.addr;
    assign transfer_size_code = cur_ff.size;
    assign byte_lane_enables  = cur_ff.be;
    assign transfer_type      = TYPE_MEMORY;
    assign bus_wr_data        = cur_ff.wdata;
    assign rsp_out            = rsp_ff;
    assign rsp_valid          = rsp_valid_ff;
    assign cmd_rejected       = rej_ff;

    // Protocol checks
    a_addr_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_ADDR && !ack_ff && !addr_to) |=> primary_addr_valid)
        else $error("address valid dropped early");

    a_no_second_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_DATA) |-> !primary_addr_valid)
        else $error("second address during data phase");

    a_addr_timeout: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_ADDR && atime_ff == 5'h0F && !wait_ff && !ack_ff) |=> state_ff == ST_IDLE)
        else $error("address timeout missed");

    a_wait_freeze: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_ADDR && wait_ff && $past(state_ff) == ST_ADDR) |=> $stable(atime_ff))
        else $error("counter ran during wait");

    a_type_memory: assert property (@(posedge clk) disable iff (sys_rst)
        primary_addr_valid |-> transfer_type == 3'h0)
        else $error("non memory transfer type");

    a_legal_size: assert property (@(posedge clk) disable iff (sys_rst)
        primary_addr_valid |-> (transfer_size_code <= 4'h3
        || (transfer_size_code >= 4'hA && transfer_size_code <= 4'hD)))
        else $error("reserved size issued");

    a_burst_len: assert property (@(posedge clk) disable iff (sys_rst)
        (primary_addr_valid && transfer_size_code >= 4'hA) |->
        (byte_lane_enables != '0 && {1'b0, byte_lane_enables} <= BURST_MAX))
        else $error("bad burst length");

    a_complete_rsp: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_DATA && done_cmp) |=> rsp_valid && !rsp_out.timeout)
        else $error("completion not reported");

    a_data_bound: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_DATA) |-> dtime_ff <= 9'(DATA_TIMEOUT))
        else $error("data counter overrun");

    a_no_abort: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_DATA && !done_cmp && !data_to) |=> state_ff == ST_DATA)
        else $error("data phase abandoned");

    a_rsp_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");

    a_reject_no_addr: assert property (@(posedge clk) disable iff (sys_rst)
        reject |=> !primary_addr_valid && cmd_rejected)
        else $error("refused command reached the bus");

    a_fields_stable: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff != ST_IDLE && $past(state_ff) != ST_IDLE) |->
        ($stable(bus_addr) && $stable(transfer_size_code)
        && $stable(byte_lane_enables) && $stable(bus_rnw)))
        else $error("qualifiers changed mid transaction");

    a_ack_to_data: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_ADDR && ack_ff) |=> state_ff == ST_DATA)
        else $error("acknowledge did not open data phase");

    a_data_timeout: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_DATA && data_to && !done_cmp) |=> rsp_valid && rsp_out.timeout)
        else $error("data timeout not reported");

    a_addr_to_rsp: assert property (@(posedge clk) disable iff (sys_rst)
        fin_addr |=> rsp_valid && rsp_out.timeout)
        else $error("address timeout not reported");

    a_idle_no_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_IDLE && !start) |=> !primary_addr_valid)
        else $error("address valid without command");

    a_start_addr: assert property (@(posedge clk) disable iff (sys_rst)
        start |=> primary_addr_valid && state_ff == ST_ADDR)
        else $error("address phase not started");

    a_addr_in_state: assert property (@(posedge clk) disable iff (sys_rst)
        primary_addr_valid |-> state_ff == ST_ADDR)
        else $error("address valid outside address phase");

    a_read_data: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_DATA && cur_ff.rnw && rc_ff) |=> rsp_out.rdata == $past(rd_ff))
        else $error("read data not returned");

    a_write_end: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_DATA && !cur_ff.rnw && wc_ff) |=> state_ff == ST_IDLE)
        else $error("write complete ignored");

    a_write_zero_data: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_DATA && !cur_ff.rnw && wc_ff) |=>
        (rsp_out.rdata == '0 && !rsp_out.rnw))
        else $error("write response carries data");

    a_addr_count: assert property (@(posedge clk) disable iff (sys_rst)
        (state_ff == ST_ADDR) |-> atime_ff <= 5'h0F)
        else $error("address counter overrun");

    a_rsp_rej_excl: assert property (@(posedge clk) disable iff (sys_rst)
        !(rsp_valid && cmd_rejected))
        else $error("response and refusal together");
endmodule
`default_nettype wire

// file: rtl/lbus_pkg.sv
/*
 * Shared constants and carrier types for the local bus master controller.
 * Assumes a single 40 MHz bus clock and a synchronous active-high reset.
 */
`default_nettype none
package lbus_pkg;
    localparam int ADDR_W           = 32;
    localparam int DATA_W           = 32;
    localparam int BE_W             = DATA_W / 8;
    localparam int CLK_PERIOD_NS    = 25;
    localparam int ADDR_TIMEOUT_CLK = 16;
    localparam int DATA_TIMEOUT_MAX = 511;
    localparam int FIFO_DEPTH       = 8;

    localparam logic [3:0] SIZE_SINGLE  = 4'h0;
    localparam logic [3:0] SIZE_LINE4   = 4'h1;
    localparam logic [3:0] SIZE_LINE8   = 4'h2;
    localparam logic [3:0] SIZE_LINE16  = 4'h3;
    localparam logic [3:0] SIZE_BURST_W = 4'hA;
    localparam logic [3:0] SIZE_BURST_D = 4'hB;
    localparam logic [3:0] SIZE_BURST_Q = 4'hC;
    localparam logic [3:0] SIZE_BURST_O = 4'hD;
    localparam logic [2:0] TYPE_MEMORY  = 3'h0;
    localparam logic [4:0] BURST_MAX    = 5'h10;

    typedef struct packed {
        logic              rnw;
        logic [3:0]        size;
        logic [BE_W-1:0]   be;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic              rnw;
        logic              timeout;
        logic [DATA_W-1:0] rdata;
    } rsp_t;
endpackage
`default_nettype wire
